// ---- src/port_gate_pkg.sv ----
package port_gate_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned PORT_COUNT = 8;
    localparam int unsigned ADDR_WIDTH = 12;
    localparam int unsigned DATA_WIDTH = 32;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] RUN_GATE_OFFSET = 12'h108;
    localparam logic [11:0] SLEEP_GATE_OFFSET = 12'h118;
    localparam logic [11:0] DEEP_GATE_OFFSET = 12'h128;
    localparam logic [11:0] CLOCK_CONFIG_OFFSET = 12'h130;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h140;
    localparam logic [11:0] IRQ_MASK_OFFSET = 12'h144;

    // ------------------------------------------------------------
    // Field positions and values after reset
    // ------------------------------------------------------------
    localparam int unsigned AUTO_GATING_POS = 0;
    localparam logic [7:0] GATE_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic AUTO_GATING_RESET = 1'b0;

    // ------------------------------------------------------------
    // Power states reported by the power controller
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        POWER_RUN,
        POWER_SLEEP,
        POWER_DEEP
    } power_state_t;

    // Aligned register address match
    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] offset);
        reg_hit = (addr == offset);
    endfunction : reg_hit

endpackage : port_gate_pkg

// ---- src/port_gate_if.sv ----
`timescale 1ns/1ps
interface port_gate_if;
    import port_gate_pkg::*;

    logic [PORT_COUNT-1:0] run_gate;
    logic [PORT_COUNT-1:0] sleep_gate;
    logic [PORT_COUNT-1:0] deep_gate;
    logic auto_gating_select;
    power_state_t power_state;
    logic [PORT_COUNT-1:0] gate_select;

    modport regs (
        output run_gate,
        output sleep_gate,
        output deep_gate,
        output auto_gating_select,
        output power_state,
        input gate_select
    );

    modport select (
        input run_gate,
        input sleep_gate,
        input deep_gate,
        input auto_gating_select,
        input power_state,
        output gate_select
    );

endinterface : port_gate_if

// ---- src/port_gate_select.sv ----
`timescale 1ns/1ps
module port_gate_select (
    // Register and state view
    port_gate_if.select bus
);
    import port_gate_pkg::*;

    // ------------------------------------------------------------
    // Per-port enable choice
    // ------------------------------------------------------------
    // per-state register, gating bit
    wire use_sleep = bus.auto_gating_select && (bus.power_state == POWER_SLEEP);
    wire use_deep = bus.auto_gating_select && (bus.power_state == POWER_DEEP);

    for (genvar i = 0; i < PORT_COUNT; i++) begin : g_port
        assign bus.gate_select[i] = use_deep ? bus.deep_gate[i] :
                                    use_sleep ? bus.sleep_gate[i] : bus.run_gate[i];
    end

endmodule : port_gate_select

// ---- src/low_power_port_clock_gating.sv ----
// Summary of operation
// - A port whose enable bit in the governing gating register is one gets its clock, else none.
// - A bus access aimed at a port whose clock is off is answered with a bus fault.
// - After reset every port enable bit of both low-power gating registers is zero.
// - Run, light sleep and deep sleep each use their own gating register.
// - The low-power registers govern only while the automatic gating bit is set.
// - Bits 31 to 8 of each low-power gating register read zero and ignore writes.
// - Bits 7 to 0 are read/write enables for ports H down to A in both registers.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module low_power_port_clock_gating (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [port_gate_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [port_gate_pkg::DATA_WIDTH-1:0] pwdata,
    output logic [port_gate_pkg::DATA_WIDTH-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power controller
    input wire port_gate_pkg::power_state_t power_state,
    // Port bus accesses
    input wire logic port_access,
    input wire logic [2:0] port_index,
    output logic port_bus_fault,
    // Port clock enables, bit 7 port H down to bit 0 port A
    output logic [port_gate_pkg::PORT_COUNT-1:0] port_clock_enable,
    // Interrupt
    output logic irq
);
    import port_gate_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [PORT_COUNT-1:0] run_gate_q;
    logic [PORT_COUNT-1:0] sleep_gate_q;
    logic [PORT_COUNT-1:0] deep_gate_q;
    logic auto_gating_q;
    logic [PORT_COUNT-1:0] status_q;
    logic [PORT_COUNT-1:0] status_d;
    logic [PORT_COUNT-1:0] mask_q;
    logic [PORT_COUNT-1:0] gate_en_q;
    logic fault_q;
    logic irq_q;
    logic pready_q;
    logic pslverr_q;
    logic [DATA_WIDTH-1:0] prdata_q;

    // ------------------------------------------------------------
    // Enable selection
    // ------------------------------------------------------------
    port_gate_if sel_bus ();

    assign sel_bus.run_gate = run_gate_q;
    assign sel_bus.sleep_gate = sleep_gate_q;
    assign sel_bus.deep_gate = deep_gate_q;
    assign sel_bus.auto_gating_select = auto_gating_q;
    assign sel_bus.power_state = power_state;

    port_gate_select u_select (
        .bus(sel_bus)
    );

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire setup_phase = psel && !penable;
    wire write_en = psel && penable && pready_q && pwrite;
    wire read_done = psel && penable && pready_q && !pwrite;
    wire hit_run = reg_hit(paddr, RUN_GATE_OFFSET);
    wire hit_sleep = reg_hit(paddr, SLEEP_GATE_OFFSET);
    wire hit_deep = reg_hit(paddr, DEEP_GATE_OFFSET);
    wire hit_config = reg_hit(paddr, CLOCK_CONFIG_OFFSET);
    wire hit_status = reg_hit(paddr, IRQ_STATUS_OFFSET);
    wire hit_mask = reg_hit(paddr, IRQ_MASK_OFFSET);
    wire hit_any = hit_run || hit_sleep || hit_deep || hit_config || hit_status || hit_mask;

    wire [DATA_WIDTH-1:0] read_word =
        hit_run ? {24'h000000, run_gate_q} :
        hit_sleep ? {24'h000000, sleep_gate_q} :
        hit_deep ? {24'h000000, deep_gate_q} :
        hit_config ? {31'h00000000, auto_gating_q} :
        hit_status ? {24'h000000, status_q} :
        hit_mask ? {24'h000000, mask_q} : 32'h00000000;

    // ------------------------------------------------------------
    // APB answer, no wait states
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= setup_phase;
            pslverr_q <= setup_phase && !hit_any;
            prdata_q <= setup_phase && !pwrite ? read_word : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // Gating registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            run_gate_q <= GATE_RESET;
            sleep_gate_q <= GATE_RESET;
            deep_gate_q <= GATE_RESET;
            auto_gating_q <= AUTO_GATING_RESET;
            mask_q <= MASK_RESET;
        end else if (write_en) begin
            if (hit_run) begin
                run_gate_q <= pwdata[7:0];
            end
            if (hit_sleep) begin
                sleep_gate_q <= pwdata[7:0];
            end
            if (hit_deep) begin
                deep_gate_q <= pwdata[7:0];
            end
            if (hit_config) begin
                auto_gating_q <= pwdata[AUTO_GATING_POS];
            end
            if (hit_mask) begin
                mask_q <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Port clock enables and fault answer
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gate_en_q <= GATE_RESET;
            fault_q <= 1'b0;
        end else begin
            gate_en_q <= sel_bus.gate_select;
            fault_q <= port_access && !gate_en_q[port_index];
        end
    end

    // ------------------------------------------------------------
    // Fault status and interrupt
    // ------------------------------------------------------------
    wire [PORT_COUNT-1:0] fault_set =
        port_access ? (~gate_en_q & (8'h01 << port_index)) : 8'h00;
    // Clear only the bits that the read returned; a fault that lands during setup stays pending
    wire [PORT_COUNT-1:0] status_clr =
        (read_done && hit_status) ? prdata_q[PORT_COUNT-1:0] : 8'h00;

    // Set beats a clearing read in the same cycle
    assign status_d = (status_q & ~status_clr) | fault_set;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            status_q <= STATUS_RESET;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_q <= |(status_d & mask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign port_bus_fault = fault_q;
    assign port_clock_enable = gate_en_q;
    assign irq = irq_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    property p_enable_tracks_select;
        ##1 port_clock_enable == $past(sel_bus.gate_select);
    endproperty
    a_enable_tracks_select: assert property (p_enable_tracks_select)
        else $error("port enable did not follow selected register");

    property p_fault_when_gated;
        port_access && !port_clock_enable[port_index] |=> port_bus_fault;
    endproperty
    a_fault_when_gated: assert property (p_fault_when_gated)
        else $error("access to gated port raised no fault");

    property p_no_fault_when_open;
        port_access && port_clock_enable[port_index] |=> !port_bus_fault;
    endproperty
    a_no_fault_when_open: assert property (p_no_fault_when_open)
        else $error("access to clocked port raised a fault");

    property p_fault_sets_status;
        port_access && !port_clock_enable[port_index] |=> status_q[$past(port_index)];
    endproperty
    a_fault_sets_status: assert property (p_fault_sets_status)
        else $error("gated port access left no status bit");

    property p_fault_one_cycle;
        port_bus_fault && !(port_access && !port_clock_enable[port_index]) |=> !port_bus_fault;
    endproperty
    a_fault_one_cycle: assert property (p_fault_one_cycle)
        else $error("port fault stood longer than one cycle");

    property p_reset_clears;
        @(posedge clock) disable iff (1'b0)
        $past(sys_rst) |-> sleep_gate_q == 8'h00 && deep_gate_q == 8'h00 &&
            port_clock_enable == 8'h00;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("gating registers not zero after reset");

    property p_reset_outputs;
        @(posedge clock) disable iff (1'b0)
        $past(sys_rst) |-> !irq && !port_bus_fault && !pready && !pslverr;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs)
        else $error("outputs not idle after reset");

    property p_run_state_used;
        auto_gating_q && power_state == POWER_RUN |=> port_clock_enable == $past(run_gate_q);
    endproperty
    a_run_state_used: assert property (p_run_state_used)
        else $error("run state did not use its gating register");

    property p_deep_state_used;
        auto_gating_q && power_state == POWER_DEEP |=> port_clock_enable == $past(deep_gate_q);
    endproperty
    a_deep_state_used: assert property (p_deep_state_used)
        else $error("deep sleep did not use its gating register");

    property p_sleep_state_used;
        auto_gating_q && power_state == POWER_SLEEP |=> port_clock_enable == $past(sleep_gate_q);
    endproperty
    a_sleep_state_used: assert property (p_sleep_state_used)
        else $error("light sleep did not use its gating register");

    property p_auto_off_uses_run;
        !auto_gating_q |=> port_clock_enable == $past(run_gate_q);
    endproperty
    a_auto_off_uses_run: assert property (p_auto_off_uses_run)
        else $error("run register not used with automatic gating off");

    property p_illegal_state_uses_run;
        auto_gating_q && power_state == power_state_t'(2'h3) |=>
            port_clock_enable == $past(run_gate_q);
    endproperty
    a_illegal_state_uses_run: assert property (p_illegal_state_uses_run)
        else $error("unknown power state did not fall back to run register");

    property p_reserved_read_zero;
        setup_phase && !pwrite && (hit_sleep || hit_deep) |=> pready && prdata[31:8] == 24'h000000;
    endproperty
    a_reserved_read_zero: assert property (p_reserved_read_zero)
        else $error("reserved gating bits read nonzero");

    property p_write_stores;
        write_en && hit_sleep |=> sleep_gate_q == $past(pwdata[7:0]);
    endproperty
    a_write_stores: assert property (p_write_stores)
        else $error("sleep gating write not stored");

    property p_deep_write_stores;
        write_en && hit_deep |=> deep_gate_q == $past(pwdata[7:0]);
    endproperty
    a_deep_write_stores: assert property (p_deep_write_stores)
        else $error("deep sleep gating write not stored");

    property p_pready_after_setup;
        setup_phase |=> pready;
    endproperty
    a_pready_after_setup: assert property (p_pready_after_setup)
        else $error("no ready in the cycle after setup");

    property p_pready_one_cycle;
        pready |=> !pready;
    endproperty
    a_pready_one_cycle: assert property (p_pready_one_cycle)
        else $error("ready stood longer than one cycle");

    property p_unmapped_error;
        setup_phase && !hit_any |=> pready && pslverr && prdata == 32'h00000000;
    endproperty
    a_unmapped_error: assert property (p_unmapped_error)
        else $error("unmapped access not answered with an error");

    property p_status_read_clears;
        read_done && hit_status && !port_access |=>
            status_q == ($past(status_q) & ~$past(prdata[PORT_COUNT-1:0]));
    endproperty
    a_status_read_clears: assert property (p_status_read_clears)
        else $error("status read cleared the wrong bits");

    property p_irq_level;
        ##1 irq == |(status_q & $past(mask_q));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level does not match masked status");

endmodule : low_power_port_clock_gating

// ---- sim/port_model.sv ----
`timescale 1ns/1ps
module port_model (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Bench request
    input wire logic go,
    input wire logic [2:0] go_index,
    // Block side
    output logic port_access,
    output logic [2:0] port_index
);
    // Between accesses the index toggles so a stale value is never trusted
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            port_access <= 1'b0;
            port_index <= 3'h0;
        end else begin
            port_access <= go;
            port_index <= go ? go_index : ~port_index;
        end
    end
endmodule : port_model

// ---- sim/low_power_port_clock_gating_bench.sv ----
`timescale 1ns/1ps
module low_power_port_clock_gating_bench;
    import port_gate_pkg::*;
    logic clock, sys_rst, psel, penable, pwrite, go, pready, pslverr, err;
    logic port_access, port_bus_fault, irq;
    logic [ADDR_WIDTH-1:0] paddr;
    logic [DATA_WIDTH-1:0] pwdata, prdata, rd;
    logic [2:0] port_index, go_index;
    logic [PORT_COUNT-1:0] port_clock_enable;
    logic [7:0] sel_exp [4];
    power_state_t power_state;
    int n_mismatch, compares, cycles;

    low_power_port_clock_gating dut_u (.clock(clock), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_state(power_state),
        .port_access(port_access), .port_index(port_index), .port_bus_fault(port_bus_fault),
        .port_clock_enable(port_clock_enable), .irq(irq));
    port_model port_u (.clock(clock), .sys_rst(sys_rst), .go(go), .go_index(go_index),
        .port_access(port_access), .port_index(port_index));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Checks and bus tasks
    // ------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input string what);
        apb(1'b0, addr, 32'h0);
        chk_word(rd, exp, what);
    endtask : rd_chk

    task automatic hit(input logic [2:0] idx, input logic exp_fault);
        @(posedge clock);
        go <= 1'b1;
        go_index <= idx;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        #1;
        chk_bit(port_bus_fault, exp_fault, "port fault");
    endtask : hit

    task automatic state(input power_state_t s, input logic [7:0] exp);
        @(posedge clock);
        power_state <= s;
        repeat (2) @(posedge clock);
        #1;
        chk_word({24'h0, port_clock_enable}, {24'h0, exp}, "port enables");
    endtask : state

    task automatic give_verdict;
        $display("TB: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, go, sys_rst} = 5'h01;
        paddr = 12'h000;
        pwdata = 32'h0;
        go_index = 3'h0;
        power_state = POWER_RUN;
        sel_exp = '{8'h0F, 8'h3C, 8'hC1, 8'h0F};
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd_chk(SLEEP_GATE_OFFSET, 32'h0, "sleep reset");
        rd_chk(DEEP_GATE_OFFSET, 32'h0, "deep reset");
        chk_word({24'h0, port_clock_enable}, 32'h0, "enables reset");
        $display("TB: reset test done");
        apb(1'b1, SLEEP_GATE_OFFSET, 32'hFFFF_FF5A);
        rd_chk(SLEEP_GATE_OFFSET, 32'h0000_005A, "sleep reserved");
        apb(1'b1, DEEP_GATE_OFFSET, 32'h1234_56A5);
        rd_chk(DEEP_GATE_OFFSET, 32'h0000_00A5, "deep reserved");
        apb(1'b0, 12'h200, 32'h0);
        chk_bit(err, 1'b1, "unmapped error");
        chk_word(rd, 32'h0, "unmapped data");
        $display("TB: register test done");
        apb(1'b1, RUN_GATE_OFFSET, 32'h0F);
        apb(1'b1, SLEEP_GATE_OFFSET, 32'h3C);
        apb(1'b1, DEEP_GATE_OFFSET, 32'hC1);
        for (int s = 0; s < 4; s++) begin
            state(power_state_t'(s), 8'h0F);
        end
        apb(1'b1, CLOCK_CONFIG_OFFSET, 32'h1);
        // Code 3 is unknown and falls back to the run register
        for (int s = 0; s < 4; s++) begin
            state(power_state_t'(s), sel_exp[s]);
        end
        state(POWER_DEEP, sel_exp[2]);
        $display("TB: selection test done");
        apb(1'b1, IRQ_MASK_OFFSET, 32'hFF);
        for (int i = 0; i < 8; i++) begin
            hit(3'(i), ~sel_exp[2][i]);
        end
        chk_bit(irq, 1'b1, "irq raised");
        rd_chk(IRQ_STATUS_OFFSET, 32'h3E, "fault status");
        @(posedge clock);
        #1;
        chk_bit(irq, 1'b0, "irq cleared");
        rd_chk(IRQ_STATUS_OFFSET, 32'h0, "status cleared");
        apb(1'b1, IRQ_MASK_OFFSET, 32'h0);
        hit(3'h1, 1'b1);
        @(posedge clock);
        #1;
        chk_bit(irq, 1'b0, "irq masked");
        rd_chk(IRQ_STATUS_OFFSET, 32'h02, "masked status");
        // Fault lands while a status read is in setup; it must survive the clear
        fork
            hit(3'h2, 1'b1);
            begin
                @(posedge clock);
                rd_chk(IRQ_STATUS_OFFSET, 32'h0, "status before late fault");
            end
        join
        rd_chk(IRQ_STATUS_OFFSET, 32'h04, "late fault kept");
        $display("TB: fault test done");
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd_chk(DEEP_GATE_OFFSET, 32'h0, "deep second reset");
        chk_word({24'h0, port_clock_enable}, 32'h0, "enables second reset");
        $display("TB: second reset test done");
        give_verdict();
    end
endmodule : low_power_port_clock_gating_bench
